// ==== bench/epas_host_model.sv ====
// Host processor model issuing register reads
`timescale 1ns/1ps
module epas_host_model
  import epas_pkg::*;
(
  input wire logic clock,
  input wire logic reg_rvalid,
  input wire logic [DATA_W-1:0] reg_rdata,
  output logic reg_rd,
  output logic [ADDR_W-1:0] reg_addr
);
  initial begin
    reg_rd = 1'b0;
    reg_addr = 5'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Read: entered at a falling edge, leaves one idle cycle after the answer
  task automatic do_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                         output bit ok);
    ok = 1'b0;
    d = 8'h00;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else begin
        @(negedge clock);
      end
    end
    @(negedge clock);
  endtask
endmodule

// ==== bench/tb.sv ====
// Self-checking testbench of the status bank
`timescale 1ns/1ps
module tb;
  import epas_pkg::*;
  localparam int PC = 10;
  localparam int WC = 50;
  logic clock, reset, reg_rd, reg_rvalid, tick, aligned, a_bit, e_bit;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_rdata;
  logic [13:0] ev;
  int num_errors, check_count;
  int cnt[7];
  int fl, run;
  logic [7:0] ovf_m, alm_m;
  logic win_m, per_m, prev_al;
  int lim[7] = '{255, 1023, 255, 255, 255, 1023, 65535};
  int obit[7] = '{7, 6, 5, 3, 2, 0, 1};
  int lens[8] = '{5, 10, 11, 30, 49, 50, 60, 30};
  //////////////////////////////////////////////////////////////////////////////
  epas_status_bank #(.PERSIST_CYCLES(PC), .WINDOW_CYCLES(WC)) i_dut (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pattern_error_evt(ev[0]), .e_bit_error_evt(ev[1]), .jitter_near_limit_evt(ev[2]),
    .frame_tick(tick), .basic_frame_aligned(aligned), .bit_error_evt(ev[3]),
    .alignment_error_evt(ev[4]), .crc4_error_evt(ev[5]), .bipolar_violation_evt(ev[6]),
    .rx_a_bit(a_bit), .rx_e_bit(e_bit), .remote_alarm_evt(ev[7]),
    .all_ones_alarm_evt(ev[8]), .slot16_all_ones_evt(ev[9]), .signal_lost_evt(ev[10]),
    .auxiliary_pattern_evt(ev[11]), .multiframe_alarm_evt(ev[12]),
    .receive_slip_evt(ev[13])
  );
  epas_host_model i_host (
    .clock(clock), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .reg_rd(reg_rd), .reg_addr(reg_addr)
  );
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Behavioural model
  always @(posedge clock) begin
    if (reset) begin
      cnt = '{default: 0};
      fl = 0;
      run = 0;
      ovf_m = 8'h00;
      alm_m = 8'h00;
      win_m = 1'b0;
      per_m = 1'b0;
      prev_al = 1'b0;
    end else begin
      if (reg_rd && reg_addr == ADDR_COUNTER_OVERFLOW_LATCH) ovf_m = 8'h00;
      if (reg_rd && reg_addr == ADDR_ALARM_REPORT_LATCH) alm_m = 8'h00;
      if (reg_rd && reg_addr == ADDR_REMOTE_ALARM_CRC_FLAGS) win_m = 1'b0;
      for (int i = 0; i < 7; i++) begin
        if (ev[i]) begin
          if (cnt[i] == lim[i]) begin
            cnt[i] = 0;
            ovf_m[obit[i]] = 1'b1;
          end else begin
            cnt[i]++;
          end
        end
      end
      for (int k = 0; k < 7; k++) if (ev[7+k]) alm_m[7-k] = 1'b1;
      if (prev_al && !aligned) begin
        fl = 0;
      end else if (tick && !aligned) begin
        if (fl == 255) begin
          fl = 0;
          ovf_m[4] = 1'b1;
        end else begin
          fl++;
        end
      end
      prev_al = aligned;
      if (a_bit && !e_bit) begin
        run++;
      end else begin
        if (run > PC && run < WC) win_m = 1'b1;
        run = 0;
      end
      per_m = run > PC;
    end
  end
  function automatic logic [7:0] exp_reg(input logic [4:0] a);
    case (a)
      ADDR_PATTERN_COUNT: return 8'(cnt[0]);
      ADDR_E_BIT_HIGH: return 8'(cnt[1] >> 8);
      ADDR_E_BIT_LOW: return 8'(cnt[1]);
      ADDR_JITTER_COUNT: return 8'(cnt[2]);
      ADDR_COUNTER_OVERFLOW_LATCH: return ovf_m;
      ADDR_FRAME_LOSS_PERIOD_COUNTER: return 8'(fl);
      ADDR_BIT_ERROR_RATE_COUNTER: return 8'(cnt[3]);
      ADDR_REMOTE_ALARM_CRC_FLAGS: return {6'h00, win_m, per_m};
      ADDR_ERRORED_ALIGNMENT_COUNTER: return 8'(cnt[4]);
      ADDR_ALARM_REPORT_LATCH: return alm_m;
      ADDR_BIPOLAR_VIOLATION_COUNT_HIGH: return 8'(cnt[6] >> 8);
      ADDR_BIPOLAR_VIOLATION_COUNT_LOW: return 8'(cnt[6]);
      ADDR_CRC4_ERROR_COUNT_HIGH: return 8'(cnt[5] >> 8);
      ADDR_CRC4_ERROR_COUNT_LOW: return 8'(cnt[5]);
      default: return UNMAPPED_READ;
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Checking and reporting
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    check_count++;
    if (seen !== expv) begin
      $display("FAIL at %0t: seen %h expected %h", $time, seen, expv);
      num_errors++;
    end
  endtask
  task automatic rd_chk(input logic [4:0] a);
    logic [7:0] e;
    logic [7:0] d;
    bit ok;
    e = exp_reg(a);
    i_host.do_read(a, d, ok);
    if (!ok) begin
      num_errors++;
      give_verdict();
    end else begin
      check(d, e);
      check(reg_rdata, e);
      check({7'h00, reg_rvalid}, 8'h00);
    end
  endtask
  task automatic rd_all();
    for (int a = 0; a < 32; a++) rd_chk(5'(a));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    reset = 1'b1;
    ev = 14'h0000;
    tick = 1'b0;
    aligned = 1'b1;
    a_bit = 1'b0;
    e_bit = 1'b0;
    void'($urandom(32'hc5f1));
    repeat (2) @(negedge clock);
    reset = 1'b0;
    rd_all();
    $display("Test reset values done");
    for (int n = 0; n < 400; n++) begin
      ev = 14'($urandom & $urandom);
      tick = ($urandom % 4) == 0;
      if ($urandom % 8 == 0) aligned = ~aligned;
      rd_chk(5'($urandom % 32));
    end
    ev = 14'h0000;
    rd_all();
    $display("Test random events done");
    ev = 14'h007F;
    tick = 1'b1;
    aligned = 1'b0;
    repeat (65540) @(negedge clock);
    ev = 14'h0000;
    tick = 1'b0;
    rd_all();
    rd_chk(ADDR_COUNTER_OVERFLOW_LATCH);
    $display("Test counter wrap done");
    for (int t = 0; t < 8; t++) begin
      a_bit = 1'b1;
      repeat ((lens[t] > 20) ? 20 : lens[t]) @(negedge clock);
      if (lens[t] > 20) begin
        rd_chk(ADDR_REMOTE_ALARM_CRC_FLAGS);
        repeat (lens[t] - 22) @(negedge clock);
      end
      if (t == 7) e_bit = 1'b1;
      else a_bit = 1'b0;
      repeat (3) @(negedge clock);
      rd_chk(ADDR_REMOTE_ALARM_CRC_FLAGS);
      rd_chk(ADDR_REMOTE_ALARM_CRC_FLAGS);
      a_bit = 1'b0;
      e_bit = 1'b0;
      @(negedge clock);
    end
    $display("Test remote alarm runs done");
    ev = 14'h3FFF;
    repeat (4) @(negedge clock);
    ev = 14'h0000;
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    rd_all();
    $display("Test reset in mid-run done");
    give_verdict();
  end
endmodule

// ==== pkg/epas_pkg.sv ====
// Constants for the E1 performance and alarm status bank
package epas_pkg;
  localparam int CLK_FREQ_HZ = 50000000;
  localparam int CLK_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int PERSIST_MIN_MS = 10;
  localparam int WINDOW_MAX_MS = 450;
  localparam int PERSIST_MIN_CYCLES = (PERSIST_MIN_MS * CLK_PER_MS + CLK_PER_MS - 1) / CLK_PER_MS
                                      * CLK_PER_MS;
  localparam int WINDOW_MAX_CYCLES = WINDOW_MAX_MS * CLK_PER_MS;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [4:0] ADDR_PATTERN_COUNT = 5'h10;
  localparam logic [4:0] ADDR_E_BIT_HIGH = 5'h13;
  localparam logic [4:0] ADDR_E_BIT_LOW = 5'h14;
  localparam logic [4:0] ADDR_JITTER_COUNT = 5'h15;
  localparam logic [4:0] ADDR_COUNTER_OVERFLOW_LATCH = 5'h16;
  localparam logic [4:0] ADDR_FRAME_LOSS_PERIOD_COUNTER = 5'h17;
  localparam logic [4:0] ADDR_BIT_ERROR_RATE_COUNTER = 5'h18;
  localparam logic [4:0] ADDR_REMOTE_ALARM_CRC_FLAGS = 5'h19;
  localparam logic [4:0] ADDR_ERRORED_ALIGNMENT_COUNTER = 5'h1A;
  localparam logic [4:0] ADDR_ALARM_REPORT_LATCH = 5'h1B;
  localparam logic [4:0] ADDR_BIPOLAR_VIOLATION_COUNT_HIGH = 5'h1C;
  localparam logic [4:0] ADDR_BIPOLAR_VIOLATION_COUNT_LOW = 5'h1D;
  localparam logic [4:0] ADDR_CRC4_ERROR_COUNT_HIGH = 5'h1E;
  localparam logic [4:0] ADDR_CRC4_ERROR_COUNT_LOW = 5'h1F;
  // Overflow latch bit positions
  localparam int PATTERN_ERROR_COUNT_OVERFLOW = 7;
  localparam int E_BIT_COUNT_OVERFLOW = 6;
  localparam int JITTER_FIFO_COUNT_OVERFLOW = 5;
  localparam int FRAME_LOSS_COUNT_OVERFLOW = 4;
  localparam int BIT_ERROR_COUNT_OVERFLOW = 3;
  localparam int ALIGNMENT_ERROR_COUNT_OVERFLOW = 2;
  localparam int BIPOLAR_VIOLATION_COUNT_OVERFLOW = 1;
  localparam int CRC_ERROR_COUNT_OVERFLOW = 0;
  // Alarm latch bit positions
  localparam int REMOTE_ALARM_FLAG = 7;
  localparam int ALL_ONES_ALARM_FLAG = 6;
  localparam int SIGNALLING_SLOT_ALL_ONES_FLAG = 5;
  localparam int SIGNAL_ABSENT_FLAG = 4;
  localparam int AUXILIARY_PATTERN_FLAG = 3;
  localparam int MULTIFRAME_ALARM_FLAG = 2;
  localparam int RECEIVE_SLIP_FLAG = 1;
  // Crc flag bit positions
  localparam int REMOTE_ALARM_CRC_WINDOW_FLAG = 1;
  localparam int REMOTE_ALARM_CRC_PERSIST_FLAG = 0;
  // Reset values and read answers
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [9:0] TEN_BIT_RESET = 10'h000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [9:0] TEN_BIT_MAX = 10'h3FF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
endpackage

// ==== src/epas_status_bank.sv ====
// E1 performance counter and alarm latch status bank
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Overflow bit 7 on pattern counter wrap
// - Overflow bit 6 on far-end counter wrap
// - Overflow bit 5 on jitter counter wrap
// - Overflow bit 4 on frame-loss counter wrap
// - Overflow bit 3 on bit-error counter wrap
// - Overflow bit 2 on alignment counter wrap
// - Overflow bit 1 on bipolar counter wrap
// - Overflow bit 0 on CRC counter wrap
// - Count misaligned frame periods, eight bits
// - Aligned-to-lost transition clears frame-loss count
// - Window flag: run 10..450 ms, read-clear
// - Persist flag high while run over 10 ms
// - Count errored alignment words, eight bits
// - Alarm bit 7 on remote alarm
// - Alarm bit 6 on all-ones alarm
// - Alarm bit 5 on slot 16 all-ones
// - Alarm bit 4 on signal loss
// - Alarm bit 3 on auxiliary pattern
// - Alarm bit 2 on multiframe alarm
// - Alarm bit 1 on slip, bit 0 zero
// - Sixteen-bit bipolar count, high then low byte
// - CRC count two high bits, upper zero
// - Ten-bit far-end count split high/low
// - Jitter count on FIFO near limit
// - Pattern count per pattern error
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module epas_status_bank
  import epas_pkg::*;
#(
  parameter int PERSIST_CYCLES = PERSIST_MIN_CYCLES,
  parameter int WINDOW_CYCLES = WINDOW_MAX_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic pattern_error_evt,
  input wire logic e_bit_error_evt,
  input wire logic jitter_near_limit_evt,
  input wire logic frame_tick,
  input wire logic basic_frame_aligned,
  input wire logic bit_error_evt,
  input wire logic alignment_error_evt,
  input wire logic crc4_error_evt,
  input wire logic bipolar_violation_evt,
  input wire logic rx_a_bit,
  input wire logic rx_e_bit,
  input wire logic remote_alarm_evt,
  input wire logic all_ones_alarm_evt,
  input wire logic slot16_all_ones_evt,
  input wire logic signal_lost_evt,
  input wire logic auxiliary_pattern_evt,
  input wire logic multiframe_alarm_evt,
  input wire logic receive_slip_evt
);

  localparam int RUN_W = $clog2(WINDOW_CYCLES + 1);

  if (PERSIST_CYCLES < 1 || WINDOW_CYCLES <= PERSIST_CYCLES + 1) begin : g_bad_times
    $error("Window cycles must exceed persist cycles by more than one");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counters

  logic [7:0] pattern_error_count_r;
  logic [9:0] e_bit_count_r;
  logic [7:0] jitter_fifo_near_limit_count_r;
  logic [7:0] frame_loss_period_count_r;
  logic [7:0] bit_error_rate_count_r;
  logic [7:0] errored_alignment_count_r;
  logic [15:0] bipolar_violation_count_r;
  logic [9:0] crc4_error_count_r;
  logic aligned_d_r;
  logic align_lost;
  logic frame_loss_inc;
  logic [7:0] ovf_set;

  assign align_lost = aligned_d_r && !basic_frame_aligned;
  assign frame_loss_inc = frame_tick && !basic_frame_aligned && !align_lost;

  // Wrap events feed the overflow latch
  always_comb begin
    ovf_set = BYTE_RESET;
    ovf_set[PATTERN_ERROR_COUNT_OVERFLOW] =
      pattern_error_evt && pattern_error_count_r == BYTE_MAX;
    ovf_set[E_BIT_COUNT_OVERFLOW] = e_bit_error_evt && e_bit_count_r == TEN_BIT_MAX;
    ovf_set[JITTER_FIFO_COUNT_OVERFLOW] =
      jitter_near_limit_evt && jitter_fifo_near_limit_count_r == BYTE_MAX;
    ovf_set[FRAME_LOSS_COUNT_OVERFLOW] =
      frame_loss_inc && frame_loss_period_count_r == BYTE_MAX;
    ovf_set[BIT_ERROR_COUNT_OVERFLOW] =
      bit_error_evt && bit_error_rate_count_r == BYTE_MAX;
    ovf_set[ALIGNMENT_ERROR_COUNT_OVERFLOW] =
      alignment_error_evt && errored_alignment_count_r == BYTE_MAX;
    ovf_set[BIPOLAR_VIOLATION_COUNT_OVERFLOW] =
      bipolar_violation_evt && bipolar_violation_count_r == WORD_MAX;
    ovf_set[CRC_ERROR_COUNT_OVERFLOW] =
      crc4_error_evt && crc4_error_count_r == TEN_BIT_MAX;
  end

  // Event counters, all wrap to zero
  always_ff @(posedge clock) begin
    if (reset) begin
      pattern_error_count_r <= BYTE_RESET;
      e_bit_count_r <= TEN_BIT_RESET;
      jitter_fifo_near_limit_count_r <= BYTE_RESET;
      bit_error_rate_count_r <= BYTE_RESET;
      errored_alignment_count_r <= BYTE_RESET;
      bipolar_violation_count_r <= WORD_RESET;
      crc4_error_count_r <= TEN_BIT_RESET;
    end else begin
      if (pattern_error_evt) begin
        pattern_error_count_r <= pattern_error_count_r + 8'h01;
      end
      if (e_bit_error_evt) begin
        e_bit_count_r <= e_bit_count_r + 10'h001;
      end
      if (jitter_near_limit_evt) begin
        jitter_fifo_near_limit_count_r <= jitter_fifo_near_limit_count_r + 8'h01;
      end
      if (bit_error_evt) begin
        bit_error_rate_count_r <= bit_error_rate_count_r + 8'h01;
      end
      if (alignment_error_evt) begin
        errored_alignment_count_r <= errored_alignment_count_r + 8'h01;
      end
      if (bipolar_violation_evt) begin
        bipolar_violation_count_r <= bipolar_violation_count_r + 16'h0001;
      end
      if (crc4_error_evt) begin
        crc4_error_count_r <= crc4_error_count_r + 10'h001;
      end
    end
  end

  // Frame-loss period counter
  always_ff @(posedge clock) begin
    if (reset) begin
      aligned_d_r <= 1'b0;
      frame_loss_period_count_r <= BYTE_RESET;
    end else begin
      aligned_d_r <= basic_frame_aligned;
      if (align_lost) begin
        frame_loss_period_count_r <= BYTE_RESET;
      end else if (frame_loss_inc) begin
        frame_loss_period_count_r <= frame_loss_period_count_r + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Remote alarm with CRC error timing

  logic remote_crc_cond;
  logic [RUN_W-1:0] run_cnt_r;
  logic persist_flag_r;
  logic window_flag_r;
  logic window_evt;

  assign remote_crc_cond = rx_a_bit && !rx_e_bit;
  assign window_evt = !remote_crc_cond && run_cnt_r > RUN_W'(PERSIST_CYCLES)
                      && run_cnt_r < RUN_W'(WINDOW_CYCLES);

  // Run length, saturating at the window limit
  always_ff @(posedge clock) begin
    if (reset) begin
      run_cnt_r <= '0;
    end else if (!remote_crc_cond) begin
      run_cnt_r <= '0;
    end else if (run_cnt_r < RUN_W'(WINDOW_CYCLES)) begin
      run_cnt_r <= run_cnt_r + RUN_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      persist_flag_r <= 1'b0;
    end else begin
      persist_flag_r <= remote_crc_cond && run_cnt_r >= RUN_W'(PERSIST_CYCLES);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read-clear latches

  logic rd_ovf;
  logic rd_alarm;
  logic rd_flags;
  logic [7:0] ovf_latch_r;
  logic [7:0] alarm_latch_r;
  logic [7:0] alarm_set;

  assign rd_ovf = reg_rd && reg_addr == ADDR_COUNTER_OVERFLOW_LATCH;
  assign rd_alarm = reg_rd && reg_addr == ADDR_ALARM_REPORT_LATCH;
  assign rd_flags = reg_rd && reg_addr == ADDR_REMOTE_ALARM_CRC_FLAGS;

  always_comb begin
    alarm_set = BYTE_RESET;
    alarm_set[REMOTE_ALARM_FLAG] = remote_alarm_evt;
    alarm_set[ALL_ONES_ALARM_FLAG] = all_ones_alarm_evt;
    alarm_set[SIGNALLING_SLOT_ALL_ONES_FLAG] = slot16_all_ones_evt;
    alarm_set[SIGNAL_ABSENT_FLAG] = signal_lost_evt;
    alarm_set[AUXILIARY_PATTERN_FLAG] = auxiliary_pattern_evt;
    alarm_set[MULTIFRAME_ALARM_FLAG] = multiframe_alarm_evt;
    alarm_set[RECEIVE_SLIP_FLAG] = receive_slip_evt;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ovf_latch_r <= BYTE_RESET;
    end else begin
      ovf_latch_r <= (rd_ovf ? BYTE_RESET : ovf_latch_r) | ovf_set;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      alarm_latch_r <= BYTE_RESET;
    end else begin
      alarm_latch_r <= (rd_alarm ? BYTE_RESET : alarm_latch_r) | alarm_set;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      window_flag_r <= 1'b0;
    end else begin
      window_flag_r <= (window_flag_r && !rd_flags) || window_evt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read port

  logic [7:0] rd_mux;

  always_comb begin
    if (reg_addr == ADDR_PATTERN_COUNT) begin
      rd_mux = pattern_error_count_r;
    end else if (reg_addr == ADDR_E_BIT_HIGH) begin
      rd_mux = {6'h00, e_bit_count_r[9:8]};
    end else if (reg_addr == ADDR_E_BIT_LOW) begin
      rd_mux = e_bit_count_r[7:0];
    end else if (reg_addr == ADDR_JITTER_COUNT) begin
      rd_mux = jitter_fifo_near_limit_count_r;
    end else if (reg_addr == ADDR_COUNTER_OVERFLOW_LATCH) begin
      rd_mux = ovf_latch_r;
    end else if (reg_addr == ADDR_FRAME_LOSS_PERIOD_COUNTER) begin
      rd_mux = frame_loss_period_count_r;
    end else if (reg_addr == ADDR_BIT_ERROR_RATE_COUNTER) begin
      rd_mux = bit_error_rate_count_r;
    end else if (reg_addr == ADDR_REMOTE_ALARM_CRC_FLAGS) begin
      rd_mux = {6'h00, window_flag_r, persist_flag_r};
    end else if (reg_addr == ADDR_ERRORED_ALIGNMENT_COUNTER) begin
      rd_mux = errored_alignment_count_r;
    end else if (reg_addr == ADDR_ALARM_REPORT_LATCH) begin
      rd_mux = alarm_latch_r;
    end else if (reg_addr == ADDR_BIPOLAR_VIOLATION_COUNT_HIGH) begin
      rd_mux = bipolar_violation_count_r[15:8];
    end else if (reg_addr == ADDR_BIPOLAR_VIOLATION_COUNT_LOW) begin
      rd_mux = bipolar_violation_count_r[7:0];
    end else if (reg_addr == ADDR_CRC4_ERROR_COUNT_HIGH) begin
      rd_mux = {6'h00, crc4_error_count_r[9:8]};
    end else if (reg_addr == ADDR_CRC4_ERROR_COUNT_LOW) begin
      rd_mux = crc4_error_count_r[7:0];
    end else begin
      rd_mux = UNMAPPED_READ;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= BYTE_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_PATTERN_WRAP: assert property (
    pattern_error_evt && pattern_error_count_r == BYTE_MAX |=>
      ovf_latch_r[PATTERN_ERROR_COUNT_OVERFLOW] && pattern_error_count_r == BYTE_RESET)
    else $error("Pattern counter wrap did not latch overflow");

  AST_OVF_READ_CLEAR: assert property (
    rd_ovf && !crc4_error_evt |=> !ovf_latch_r[CRC_ERROR_COUNT_OVERFLOW])
    else $error("Overflow latch not cleared by read");

  AST_BPV_WRAP: assert property (
    bipolar_violation_evt && bipolar_violation_count_r == WORD_MAX |=>
      bipolar_violation_count_r == WORD_RESET
      && ovf_latch_r[BIPOLAR_VIOLATION_COUNT_OVERFLOW])
    else $error("Bipolar counter wrap did not latch overflow");

  AST_FRAME_LOSS_CLEAR: assert property (
    align_lost |=> frame_loss_period_count_r == BYTE_RESET)
    else $error("Frame-loss count not cleared on alignment loss");

  AST_FRAME_LOSS_INC: assert property (
    frame_loss_inc |=> frame_loss_period_count_r == 8'($past(frame_loss_period_count_r) + 1))
    else $error("Frame-loss count did not advance");

  AST_PERSIST_CAUSE: assert property (
    remote_crc_cond ##1 persist_flag_r |-> $past(run_cnt_r, 1) >= RUN_W'(PERSIST_CYCLES))
    else $error("Persist flag raised too early");

  AST_WINDOW_SET: assert property (
    window_evt && !rd_flags ##1 !rd_flags |-> window_flag_r ##1 window_flag_r)
    else $error("Window flag not held after qualifying run");

  AST_ALARM_SET_WINS: assert property (
    remote_alarm_evt && rd_alarm |=> alarm_latch_r[REMOTE_ALARM_FLAG])
    else $error("Remote alarm lost against a read");

  AST_ALARM_BIT0: assert property (
    alarm_latch_r[0] == 1'b0)
    else $error("Unused alarm bit set");

  AST_CRC_HIGH_READ: assert property (
    reg_rd && reg_addr == ADDR_CRC4_ERROR_COUNT_HIGH |=>
      reg_rvalid && reg_rdata[7:2] == 6'h00 && reg_rdata[1:0] == $past(crc4_error_count_r[9:8]))
    else $error("CRC high byte read wrong");

  AST_E_BIT_WRAP: assert property (
    e_bit_error_evt && e_bit_count_r == TEN_BIT_MAX |=>
      ovf_latch_r[E_BIT_COUNT_OVERFLOW] && e_bit_count_r == TEN_BIT_RESET)
    else $error("Far-end counter wrap did not latch overflow");

  AST_JITTER_WRAP: assert property (
    jitter_near_limit_evt && jitter_fifo_near_limit_count_r == BYTE_MAX |=>
      ovf_latch_r[JITTER_FIFO_COUNT_OVERFLOW] && jitter_fifo_near_limit_count_r == BYTE_RESET)
    else $error("Jitter counter wrap did not latch overflow");

  AST_FRAME_LOSS_WRAP: assert property (
    frame_loss_inc && frame_loss_period_count_r == BYTE_MAX |=>
      ovf_latch_r[FRAME_LOSS_COUNT_OVERFLOW] && frame_loss_period_count_r == BYTE_RESET)
    else $error("Frame-loss counter wrap did not latch overflow");

  AST_BIT_ERROR_WRAP: assert property (
    bit_error_evt && bit_error_rate_count_r == BYTE_MAX |=>
      ovf_latch_r[BIT_ERROR_COUNT_OVERFLOW] && bit_error_rate_count_r == BYTE_RESET)
    else $error("Bit error counter wrap did not latch overflow");

  AST_ALIGN_ERROR_INC: assert property (
    alignment_error_evt |=>
      errored_alignment_count_r == 8'($past(errored_alignment_count_r) + 1))
    else $error("Errored alignment count did not advance");

  AST_CRC_WRAP: assert property (
    crc4_error_evt && crc4_error_count_r == TEN_BIT_MAX |=>
      ovf_latch_r[CRC_ERROR_COUNT_OVERFLOW] && crc4_error_count_r == TEN_BIT_RESET)
    else $error("CRC counter wrap did not latch overflow");

  AST_PERSIST_DROP: assert property (
    !remote_crc_cond |=> !persist_flag_r)
    else $error("Persist flag held after run broke");

  AST_ALARM_READ_CLEAR: assert property (
    rd_alarm && !remote_alarm_evt |=> !alarm_latch_r[REMOTE_ALARM_FLAG])
    else $error("Alarm latch not cleared by read");

endmodule
